// ### common/sleep_wake_params.svh
/*
 * constants for the sleep and wake-up controller: reset values,
 * the interrupt vector and the oscillator restart time.
 * assumes the core clock runs at 50 MHz.
 */
`ifndef SLEEP_WAKE_PARAMS_SVH
`define SLEEP_WAKE_PARAMS_SVH

`define CLK_PERIOD_NS 20
`define RESTART_NS    320
`define RESTART_CYC   ((`RESTART_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PC_WIDTH      13
`define IRQ_VECTOR    13'h0004
`define TIMEOUT_RST   1'b1
`define POWERDOWN_RST 1'b1
`define CNT_WIDTH     8

`endif

// ### common/sleep_wake_pkg.sv
/*
 * types for the sleep and wake-up controller.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package sleep_wake_pkg;

    typedef enum logic [1:0] {
        st_run     = 2'b00,
        st_sleep   = 2'b01,
        st_restart = 2'b10
    } power_state_e;

endpackage : sleep_wake_pkg

// ### logic/wake_qualifier.sv
/*
 * qualifies interrupt flags against their enables, both for the
 * awake core and for the sleeping core.
 * assumes flags and enables are synchronous to core_clk.
 */
`timescale 1ns/1ps

module wake_qualifier (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // sources
    input  wire logic int_flag,
    input  wire logic int_en,
    input  wire logic port_b_change,
    input  wire logic port_b_change_en,
    input  wire logic periph_en,
    input  wire logic adc_done_flag,
    input  wire logic adc_done_en,
    input  wire logic adc_rc_clock,
    input  wire logic other_periph_pending,
    // results
    output logic      irq_pending,
    output logic      irq_wake
);

    function automatic logic armed(input logic flag, input logic en);
        armed = flag && en;
    endfunction : armed

    logic core_src;
    logic adc_src;

    // only the enabled sources count, global enable ignored
    assign core_src = armed(int_flag, int_en) || armed(port_b_change, port_b_change_en); // [R8]
    assign adc_src  = periph_en && armed(adc_done_flag, adc_done_en);

    assign irq_pending = core_src || adc_src || (periph_en && other_periph_pending);
    // asleep: other peripherals have no phase clocks, adc only on rc clock
    assign irq_wake    = core_src || (adc_src && adc_rc_clock); // [R5] [R6] [R1]

    a_periph_gate: assert property (@(posedge core_clk) disable iff (rst)
        (!core_src && !adc_rc_clock) |-> !irq_wake) // [R5]
        else $error("peripheral woke core without rc adc clock");

endmodule : wake_qualifier

// ### logic/sleep_wakeup_controller.sv
/*
 * sleep entry and wake-up control of the core: watchdog clear,
 * timeout and power-down flags, wake source qualification, oscillator
 * and phase clock gating, resume with or without vectoring.
 * assumes a cpu sequencer that pulses sleep_exec and clrwdt_exec for
 * one cycle, and a watchdog on its own clock that pulses
 * watchdog_timeout synchronously to core_clk.
 */
`timescale 1ns/1ps
`include "sleep_wake_params.svh"

// Summary of operation
// R1: wake on reset pin, watchdog, or interrupt
// R2: reset pin resets; other wakes resume execution
// R3: power-down flag set at power-up, cleared by sleep
// R4: watchdog time-out clears timeout flag
// R5: asleep, of the peripherals only rc-clocked adc completion wakes
// R6: phase clocks stop while asleep
// R7: sleep prefetches instruction at pc plus one
// R8: enabled interrupts wake regardless of global enable
// R9: global enable clear: continue after sleep
// R10: global enable set: next instruction, then vector
// R11: pending interrupt makes sleep a no-operation
// R12: late interrupt: sleep completes, then wakes
// R13: sleep stops oscillator driver, pins hold state
// R14: watchdog runs asleep; its time-out wakes
// R15: restart clocks before fetching, registers unchanged
module sleep_wakeup_controller
    import sleep_wake_pkg::*;
#(
    parameter int PC_WIDTH       = `PC_WIDTH,
    parameter int RESTART_CYCLES = `RESTART_CYC
) (
    // clock and reset
    input  wire logic                core_clk,
    input  wire logic                rst,
    // cpu sequencer
    input  wire logic                sleep_exec,
    input  wire logic                clrwdt_exec,
    input  wire logic [PC_WIDTH-1:0] pc,
    input  wire logic                global_irq_enable,
    output logic                     prefetch_req,
    output logic [PC_WIDTH-1:0]      prefetch_addr,
    output logic                     resume,
    output logic                     resume_vector,
    output logic [PC_WIDTH-1:0]      vector_addr,
    // reset pin and device reset
    input  wire logic                external_reset_pin_n,
    output logic                     device_reset,
    // interrupt sources
    input  wire logic                int_flag,
    input  wire logic                int_en,
    input  wire logic                port_b_change,
    input  wire logic                port_b_change_en,
    input  wire logic                periph_en,
    input  wire logic                adc_done_flag,
    input  wire logic                adc_done_en,
    input  wire logic                adc_rc_clock,
    input  wire logic                other_periph_pending,
    // watchdog
    input  wire logic                watchdog_enable,
    input  wire logic                watchdog_timeout,
    output logic                     watchdog_clear,
    output logic                     watchdog_reset,
    // status and power
    output logic                     timeout_flag,
    output logic                     powerdown_flag,
    output logic                     asleep,
    output logic                     osc_drive_en,
    output logic                     phase_clk_en,
    output logic                     io_hold
);

    localparam int WAKE_MAX = RESTART_CYCLES + 2;
    localparam logic [`CNT_WIDTH-1:0] RESTART_LAST = `CNT_WIDTH'(RESTART_CYCLES - 1);

    power_state_e          state;
    power_state_e          next_state;
    logic [`CNT_WIDTH-1:0] restart_cnt;
    logic [`CNT_WIDTH-1:0] next_restart_cnt;
    logic                  next_timeout_flag;
    logic                  next_powerdown_flag;
    logic                  next_resume_vector;
    logic [PC_WIDTH-1:0]   next_prefetch_addr;
    logic                  pend;
    logic                  next_pend;
    logic                  irq_pending;
    logic                  irq_wake;
    logic                  wd_fire;
    logic                  pin_ok;
    logic                  sleep_go;

    wake_qualifier u_qual (
        .core_clk             (core_clk),
        .rst                  (rst),
        .int_flag             (int_flag),
        .int_en               (int_en),
        .port_b_change        (port_b_change),
        .port_b_change_en     (port_b_change_en),
        .periph_en            (periph_en),
        .adc_done_flag        (adc_done_flag),
        .adc_done_en          (adc_done_en),
        .adc_rc_clock         (adc_rc_clock),
        .other_periph_pending (other_periph_pending),
        .irq_pending          (irq_pending),
        .irq_wake             (irq_wake)
    );

    // event qualification
    assign pin_ok   = external_reset_pin_n;
    assign wd_fire  = watchdog_enable && watchdog_timeout;
    // pending before the sleep cycle turns sleep into a no-op
    assign sleep_go = (state == st_run) && sleep_exec && !pend && pin_ok; // [R11] [R12]

    // outputs to the sequencer and watchdog
    assign device_reset   = !pin_ok; // [R2]
    assign watchdog_clear = sleep_go || ((state == st_run) && clrwdt_exec && pin_ok); // [R12]
    assign watchdog_reset = wd_fire && (state == st_run) && pin_ok;
    assign prefetch_req   = (state == st_run) && sleep_exec && pin_ok; // [R7]
    assign resume         = (state == st_restart) && (restart_cnt == '0) && pin_ok; // [R15]
    assign vector_addr    = PC_WIDTH'(`IRQ_VECTOR); // [R10]

    // power gating
    assign asleep       = (state == st_sleep);
    assign osc_drive_en = (state != st_sleep); // [R13]
    assign phase_clk_en = (state == st_run); // [R6] [R15]
    assign io_hold      = (state != st_run); // [R13]

    always_comb begin
        next_state          = state;
        next_restart_cnt    = restart_cnt;
        next_timeout_flag   = timeout_flag;
        next_powerdown_flag = powerdown_flag;
        next_resume_vector  = resume_vector;
        next_prefetch_addr  = prefetch_addr;
        next_pend           = irq_pending;
        if (!pin_ok) begin
            next_state       = st_run; // [R2]
            next_restart_cnt = '0;
        end else begin
            case (state)
                st_run: begin
                    if (sleep_exec) begin
                        next_prefetch_addr = pc + PC_WIDTH'(1); // [R7]
                    end
                    if (sleep_go) begin
                        next_state          = st_sleep;
                        next_powerdown_flag = 1'b0; // [R3]
                        next_timeout_flag   = 1'b1; // [R12]
                    end else if (clrwdt_exec) begin
                        next_powerdown_flag = 1'b1;
                        next_timeout_flag   = 1'b1;
                    end
                end
                st_sleep: begin
                    next_pend = 1'b0;
                    if (wd_fire || irq_wake) begin
                        next_state         = st_restart; // [R1] [R14]
                        next_restart_cnt   = RESTART_LAST;
                        next_resume_vector = irq_wake && !wd_fire && global_irq_enable; // [R8] [R9] [R10]
                    end
                end
                st_restart: begin
                    next_pend = 1'b0;
                    if (restart_cnt == '0) begin
                        next_state = st_run; // [R15]
                    end else begin
                        next_restart_cnt = restart_cnt - `CNT_WIDTH'(1);
                    end
                end
                default: begin
                    next_state = st_run;
                end
            endcase
            if (wd_fire) begin
                next_timeout_flag = 1'b0; // [R4]
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state          <= st_run;
            restart_cnt    <= '0;
            timeout_flag   <= `TIMEOUT_RST;
            powerdown_flag <= `POWERDOWN_RST; // [R3]
            resume_vector  <= 1'b0;
            prefetch_addr  <= '0;
            pend           <= 1'b0;
        end else begin
            state          <= next_state;
            restart_cnt    <= next_restart_cnt;
            timeout_flag   <= next_timeout_flag;
            powerdown_flag <= next_powerdown_flag;
            resume_vector  <= next_resume_vector;
            prefetch_addr  <= next_prefetch_addr;
            pend           <= next_pend;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_sleep_entry;
        sleep_go && !wd_fire;
    endsequence

    sequence s_irq_wake_gie(bit g);
        asleep && irq_wake && !wd_fire && pin_ok && (global_irq_enable == g);
    endsequence

    sequence s_wake_event;
        asleep && pin_ok && (wd_fire || irq_wake);
    endsequence

    sequence s_late_irq;
        s_sleep_entry ##1 (irq_wake && pin_ok);
    endsequence

    sequence s_restart_done;
        (state == st_restart) && (restart_cnt == '0) && pin_ok;
    endsequence

    sequence s_restart_entry;
        (state == st_sleep) ##1 (state == st_restart);
    endsequence

    sequence s_sleep_refused;
        (state == st_run) && sleep_exec && pend && pin_ok && !clrwdt_exec && !wd_fire;
    endsequence

    a_sleep_entry: assert property (s_sleep_entry |=> asleep && !powerdown_flag && timeout_flag) // [R3] [R12]
        else $error("sleep entry did not update flags");

    a_sleep_nop: assert property ((state == st_run) && sleep_exec && pend && pin_ok && !clrwdt_exec
        |-> !watchdog_clear ##1 (state == st_run) && $stable(powerdown_flag)) // [R11]
        else $error("sleep with pending interrupt was not a no-op");

    a_wdt_flag: assert property (wd_fire && pin_ok |=> !timeout_flag) // [R4]
        else $error("watchdog time-out did not clear timeout flag");

    a_wdt_wakes: assert property (asleep && wd_fire && pin_ok |-> !watchdog_reset ##1 (state == st_restart)) // [R14]
        else $error("watchdog time-out asleep did not wake");

    a_wake_resume: assert property (s_irq_wake_gie(1'b0) or s_irq_wake_gie(1'b1)
        |=> !phase_clk_en ##[1:WAKE_MAX] resume) // [R15] [R8]
        else $error("wake did not resume in time");

    a_no_vector: assert property (s_irq_wake_gie(1'b0) |=> !resume_vector) // [R9]
        else $error("vectoring with global enable clear");

    a_vector: assert property (s_irq_wake_gie(1'b1) |=> resume_vector) // [R10]
        else $error("no vectoring with global enable set");

    a_reset_pin: assert property (!pin_ok |-> device_reset ##1 (state == st_run)) // [R2]
        else $error("reset pin did not reset the sequencer");

    a_sleep_gating: assert property (asleep |-> !osc_drive_en && !phase_clk_en && io_hold) // [R6] [R13]
        else $error("clocks or pins not held asleep");

    a_prefetch: assert property (prefetch_req |=> prefetch_addr == $past(pc) + PC_WIDTH'(1)) // [R7]
        else $error("prefetch address is not pc plus one");

    a_late_wake: assert property (s_late_irq |=> (state == st_restart) && !powerdown_flag) // [R12]
        else $error("interrupt during sleep entry did not wake");

    a_wake_any: assert property (s_wake_event |=> !asleep && osc_drive_en) // [R1] [R15]
        else $error("wake event left the core asleep");

    a_wake_keeps_pd: assert property (s_wake_event |=> $stable(powerdown_flag)) // [R3] [R15]
        else $error("wake changed the power-down flag");

    a_stay_asleep: assert property (asleep && pin_ok && !wd_fire && !irq_wake |=> asleep) // [R5] [R6]
        else $error("core woke without a qualified event");

    a_gie_ignored: assert property (asleep && irq_wake && pin_ok && !global_irq_enable |=> !asleep) // [R8]
        else $error("global enable clear blocked an interrupt wake");

    a_asleep_no_rst: assert property (asleep |-> !watchdog_reset) // [R14]
        else $error("watchdog reset raised while asleep");

    a_wdt_reset_run: assert property (wd_fire && (state == st_run) && pin_ok |-> watchdog_reset) // [R14]
        else $error("watchdog time-out while running gave no reset");

    a_sleep_clear: assert property (sleep_go |-> watchdog_clear && prefetch_req) // [R7] [R12]
        else $error("completed sleep did not clear watchdog or prefetch");

    a_nop_flags: assert property (s_sleep_refused |=> $stable(timeout_flag) && (state == st_run)) // [R11]
        else $error("refused sleep changed timeout flag or state");

    a_run_clocks: assert property ((state == st_run) |-> osc_drive_en && phase_clk_en && !io_hold) // [R15]
        else $error("clocks or pins wrong while running");

    a_restart_gate: assert property ((state == st_restart) |-> osc_drive_en && !phase_clk_en && io_hold) // [R15]
        else $error("clocks or pins wrong while restarting");

    a_resume_run: assert property (s_restart_done |-> resume ##1 (state == st_run) && phase_clk_en) // [R15]
        else $error("restart end did not resume execution");

    a_restart_load: assert property (s_restart_entry |-> restart_cnt == RESTART_LAST) // [R15]
        else $error("restart counter not loaded on wake");

    a_regs_restart: assert property ((state == st_restart) && pin_ok && !wd_fire // [R15]
        |=> $stable(prefetch_addr) && $stable(powerdown_flag) && $stable(timeout_flag))
        else $error("registers changed during restart");

    a_vector_addr: assert property (resume && resume_vector |-> vector_addr == PC_WIDTH'(`IRQ_VECTOR)) // [R10]
        else $error("vector address wrong at resume");

endmodule : sleep_wakeup_controller

// ### verification/irq_source_model.sv
/* interrupt flag and watchdog time-out source model.
   assumes bench commands change just after core_clk rises. */
`timescale 1ns/1ps
module irq_source_model (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // commands
    input  wire logic [2:0] raise,
    input  wire logic       clear,
    input  wire logic       fire_watchdog,
    // sources
    output logic            int_flag,
    output logic            port_b_change,
    output logic            adc_done_flag,
    output logic            watchdog_timeout
);
    // flags stay set until cleared; time-out is a one-cycle pulse
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            {int_flag, port_b_change, adc_done_flag, watchdog_timeout} <= 4'h0;
        end else begin
            {int_flag, port_b_change, adc_done_flag} <= clear ? 3'h0 :
                {int_flag, port_b_change, adc_done_flag} | raise;
            watchdog_timeout <= fire_watchdog;
        end
    end
endmodule : irq_source_model

// ### verification/test_sleep_wakeup_controller.sv
/* self-checking bench of the sleep and wake-up controller.
   assumes the source model drives flags and time-outs. */
`timescale 1ns/1ps
`include "sleep_wake_params.svh"
module test_sleep_wakeup_controller;
    import sleep_wake_pkg::*;
    localparam int RC = 2;
    logic        core_clk, rst, sleep_exec, clrwdt_exec, global_irq_enable, external_reset_pin_n;
    logic        int_en, port_b_change_en, periph_en, adc_done_en, adc_rc_clock, other_periph_pending;
    logic        watchdog_enable, clear, fire_watchdog, int_flag, port_b_change, adc_done_flag;
    logic        watchdog_timeout, prefetch_req, resume, resume_vector, device_reset, watchdog_clear;
    logic        watchdog_reset, timeout_flag, powerdown_flag, asleep, osc_drive_en, phase_clk_en, io_hold;
    logic [12:0] pc, prefetch_addr, vector_addr;
    logic [2:0]  raise;
    int          failures, n_compared, seed, i, k;

    sleep_wakeup_controller #(.PC_WIDTH(13), .RESTART_CYCLES(RC)) u_dut (.core_clk, .rst, .sleep_exec,
        .clrwdt_exec, .pc, .global_irq_enable, .prefetch_req, .prefetch_addr, .resume, .resume_vector,
        .vector_addr, .external_reset_pin_n, .device_reset, .int_flag, .int_en, .port_b_change,
        .port_b_change_en, .periph_en, .adc_done_flag, .adc_done_en, .adc_rc_clock, .other_periph_pending,
        .watchdog_enable, .watchdog_timeout, .watchdog_clear, .watchdog_reset, .timeout_flag,
        .powerdown_flag, .asleep, .osc_drive_en, .phase_clk_en, .io_hold);
    irq_source_model u_src (.core_clk, .rst, .raise, .clear, .fire_watchdog, .int_flag, .port_b_change,
        .adc_done_flag, .watchdog_timeout);

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic chk(input logic [12:0] got, input logic [12:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick

    task automatic report_and_stop;
        if (failures == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop

    task automatic clr_watchdog;
        clrwdt_exec = 1'b1;
        #2;
        chk(watchdog_clear, 1'b1);
        tick(1);
        clrwdt_exec = 1'b0;
    endtask : clr_watchdog

    task automatic go_sleep(input logic [12:0] addr, input logic ok);
        sleep_exec = 1'b1;
        pc = addr;
        #2;
        chk(watchdog_clear, ok);
        chk(prefetch_req, 1'b1);
        tick(1);
        sleep_exec = 1'b0;
        chk(prefetch_addr, addr + 13'h0001);
        chk(asleep, ok);
        chk(powerdown_flag, !ok);
        chk(timeout_flag, 1'b1);
        chk(osc_drive_en, !ok);
        chk(phase_clk_en, !ok);
        chk(io_hold, ok);
    endtask : go_sleep

    task automatic wake_check(input logic vec);
        for (i = 0; i < 8 && asleep !== 1'b0; i++) tick(1);
        chk(asleep, 1'b0);
        chk(device_reset, 1'b0);
        chk(resume_vector, vec);
        chk(vector_addr, `IRQ_VECTOR);
        chk(phase_clk_en, 1'b0);
        chk(osc_drive_en, 1'b1);
        tick(RC - 1);
        chk(resume, 1'b1);
        tick(1);
        chk(phase_clk_en, 1'b1);
        chk(io_hold, 1'b0);
    endtask : wake_check

    initial begin
        #40000;
        failures++;
        report_and_stop;
    end

    initial begin
        seed = 66;
        {sleep_exec, clrwdt_exec, global_irq_enable, int_en, port_b_change_en, periph_en} = 6'h00;
        {adc_done_en, adc_rc_clock, other_periph_pending, watchdog_enable, clear, fire_watchdog} = 6'h00;
        external_reset_pin_n = 1'b1;
        pc = 13'h0000;
        raise = 3'h0;
        rst = 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        rst = 1'b0;
        chk(timeout_flag, 1'b1);
        chk(powerdown_flag, 1'b1);
        for (k = 0; k < 3; k++) begin
            {int_en, port_b_change_en, adc_done_en} = 3'h4 >> k;
            {periph_en, adc_rc_clock} = 2'h3;
            global_irq_enable = (k == 2) ? !global_irq_enable : 1'($random(seed));
            clr_watchdog;
            if (k == 1) raise = 3'h2;
            go_sleep(13'($random(seed)), 1'b1);
            raise = 3'h4 >> k;
            tick(1);
            raise = 3'h0;
            wake_check(global_irq_enable);
            chk(timeout_flag, 1'b1);
            clear = 1'b1;
            tick(1);
            clear = 1'b0;
        end
        {int_en, port_b_change_en, adc_rc_clock, other_periph_pending, global_irq_enable} = 5'h01;
        adc_done_en = 1'b1;
        clr_watchdog;
        go_sleep(13'h1FFF, 1'b1);
        raise = 3'h5;
        other_periph_pending = 1'b1;
        fire_watchdog = 1'b1;
        tick(1);
        {raise, fire_watchdog} = 4'h0;
        tick(4);
        chk(asleep, 1'b1);
        watchdog_enable = 1'b1;
        fire_watchdog = 1'b1;
        tick(1);
        fire_watchdog = 1'b0;
        wake_check(1'b0);
        chk(timeout_flag, 1'b0);
        {clear, other_periph_pending, int_en} = 3'h5;
        tick(1);
        clear = 1'b0;
        raise = 3'h4;
        tick(2);
        raise = 3'h0;
        clr_watchdog;
        go_sleep(13'($random(seed)), 1'b0);
        clear = 1'b1;
        fire_watchdog = 1'b1;
        tick(1);
        {clear, fire_watchdog} = 2'h0;
        #2;
        chk(watchdog_reset, 1'b1);
        tick(1);
        chk(timeout_flag, 1'b0);
        clr_watchdog;
        go_sleep(13'h0000, 1'b1);
        external_reset_pin_n = 1'b0;
        #2;
        chk(device_reset, 1'b1);
        tick(1);
        external_reset_pin_n = 1'b1;
        chk(asleep, 1'b0);
        chk(powerdown_flag, 1'b0);
        tick(2);
        report_and_stop;
    end
endmodule : test_sleep_wakeup_controller
